// ### common/fpsl_map.svh
`ifndef FPSL_MAP_SVH
`define FPSL_MAP_SVH
`define FPSL_CTRL_OFS 32'h0000_0000
`define FPSL_STAT_OFS 32'h0000_0004
`define FPSL_CTRL_RST 6'h3f
`define FPSL_STAT_IN_GAP 2'h0
`define FPSL_CLK_NS 20
`define FPSL_NS_PER_MS 1000000
`define FPSL_FAST_HALF_MS 250
`define FPSL_SLOW_HALF_MS 1000
`define FPSL_LED_HB 0
`define FPSL_LED_NAND 1
`define FPSL_LED_BASE 2
`define FPSL_LED_QDR 3
`define FPSL_LED_DDR 4
`define FPSL_LED_SRIO 5
`define FPSL_BLINK_BASE 0
`define FPSL_BLINK_N 3
`endif

// ### common/fpsl_pkg.sv
package fpsl_pkg;
  typedef logic [5:0] fpsl_led_t;
  typedef logic [31:0] fpsl_word_t;
endpackage

// ### common/fpsl_blink_if.sv
`timescale 1ns/1ps
interface fpsl_blink_if;
  logic enable;
  logic led;
  modport ctrl (output enable, input led);
  modport gen (input enable, output led);
endinterface

// ### src/fpsl_blink.sv
`timescale 1ns/1ps
module fpsl_blink #(
  parameter int unsigned HALF = 4
) (
  input wire logic clk,
  input wire logic rst,
  fpsl_blink_if.gen bl
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic led_q;
  logic led_d;

  // Equal halves of HALF cycles each; off and reset while disabled
  always_comb begin
    cnt_d = cnt_q;
    led_d = led_q;
    if (!bl.enable) begin
      cnt_d = '0;
      led_d = 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
      led_d = !led_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      led_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      led_q <= led_d;
    end
  end

  assign bl.led = led_q;

  blink_toggle_a: assert property (@(posedge clk) disable iff (rst)
    bl.enable && cnt_q == LAST |=> led_q != $past(led_q))
    else $error("blink did not toggle at end of half period");
  blink_hold_a: assert property (@(posedge clk) disable iff (rst)
    bl.enable && cnt_q != LAST ##1 bl.enable |-> led_q == $past(led_q))
    else $error("blink changed inside a half period");
endmodule

// ### src/fpsl_top.sv
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "fpsl_map.svh"
// Function
// - Six LEDs: two processor, four logic
// - First LED follows operating system heartbeat
// - Second LED shows NAND flash activity
// - Third LED blinks 2 Hz with clock running
// - Fourth LED blinks 0.5 Hz after QDR init
// - Fifth LED blinks 0.5 Hz after DDR init
// - Sixth LED steady on after link init
module fpsl_top import fpsl_pkg::*; #(
  parameter int unsigned FAST_HALF =
    `FPSL_FAST_HALF_MS * `FPSL_NS_PER_MS / `FPSL_CLK_NS,
  parameter int unsigned SLOW_HALF =
    `FPSL_SLOW_HALF_MS * `FPSL_NS_PER_MS / `FPSL_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic os_heartbeat,
  input wire logic nand_active,
  input wire logic base_clk_running,
  input wire logic qdr_init_done,
  input wire logic ddr_init_done,
  input wire logic srio_init_done,
  output logic [5:0] led
);
  fpsl_led_t in_raw;
  fpsl_led_t s1_q;
  fpsl_led_t s2_q;
  fpsl_led_t led_q;
  fpsl_led_t led_d;
  fpsl_led_t ctrl_q;
  fpsl_led_t ctrl_d;
  fpsl_led_t ctrl_now;
  fpsl_word_t rdata_q;
  fpsl_word_t rdata_d;
  logic wr_q;
  logic wr_d;
  logic [`FPSL_BLINK_N-1:0] blink_en;
  logic [`FPSL_BLINK_N-1:0] blink_led;
  logic take;

  // Inputs use the same bit order as the LEDs they light
  assign in_raw = {srio_init_done, ddr_init_done, qdr_init_done,
                   base_clk_running, nand_active, os_heartbeat};

  // Two-flop synchronisers; s1_q is read by s2_q only
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= in_raw;
      s2_q <= s1_q;
    end
  end

  // Zero-wait AHB-Lite slave, always OKAY
  assign take = hsel && hready && htrans[1];
  // A write still in its data phase is forwarded to a read behind it
  assign ctrl_now = wr_q ? hwdata[5:0] : ctrl_q;

  always_comb begin
    ctrl_d = ctrl_now;
    rdata_d = rdata_q;
    wr_d = 1'b0;
    if (take) begin
      if (hwrite) begin
        wr_d = (haddr == `FPSL_CTRL_OFS);
      end else if (haddr == `FPSL_CTRL_OFS) begin
        rdata_d = 32'(ctrl_now);
      end else if (haddr == `FPSL_STAT_OFS) begin
        rdata_d = 32'({s2_q, `FPSL_STAT_IN_GAP, led_q});
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `FPSL_CTRL_RST;
      rdata_q <= '0;
      wr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      wr_q <= wr_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Blinkers only run while their source says ready
  assign blink_en[0] = ctrl_q[`FPSL_LED_BASE] && s2_q[`FPSL_LED_BASE];
  assign blink_en[1] = ctrl_q[`FPSL_LED_QDR] && s2_q[`FPSL_LED_QDR];
  assign blink_en[2] = ctrl_q[`FPSL_LED_DDR] && s2_q[`FPSL_LED_DDR];

  genvar gi;
  generate
    for (gi = 0; gi < `FPSL_BLINK_N; gi++) begin : g_blink
      fpsl_blink_if bl ();
      assign bl.enable = blink_en[gi];
      assign blink_led[gi] = bl.led;
      fpsl_blink #(
        .HALF(gi == 0 ? FAST_HALF : SLOW_HALF)
      ) u_blink (
        .clk(clk),
        .rst(rst),
        .bl(bl)
      );
    end
  endgenerate

  // Heartbeat and flash activity pass straight through: the processor
  // already shapes them, so no extra stretching is added
  always_comb begin
    led_d[`FPSL_LED_HB] = ctrl_q[`FPSL_LED_HB] && s2_q[`FPSL_LED_HB];
    led_d[`FPSL_LED_NAND] =
      ctrl_q[`FPSL_LED_NAND] && s2_q[`FPSL_LED_NAND];
    led_d[`FPSL_LED_DDR:`FPSL_LED_BASE] = blink_led;
    led_d[`FPSL_LED_SRIO] =
      ctrl_q[`FPSL_LED_SRIO] && s2_q[`FPSL_LED_SRIO];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      led_q <= '0;
    end else begin
      led_q <= led_d;
    end
  end

  assign led = led_q;

  reset_dark_a: assert property (@(posedge clk)
    rst |=> led_q == '0 && ctrl_q == `FPSL_CTRL_RST)
    else $error("LEDs not dark after reset");
  heartbeat_follow_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_q[`FPSL_LED_HB] ##0 $changed(s2_q[`FPSL_LED_HB]) |=>
    led_q[`FPSL_LED_HB] == $past(s2_q[`FPSL_LED_HB]))
    else $error("heartbeat LED not following input");
  nand_flash_a: assert property (@(posedge clk) disable iff (rst)
    led_q[`FPSL_LED_NAND] |-> $past(s2_q[`FPSL_LED_NAND]))
    else $error("flash LED lit without activity");
  base_dark_a: assert property (@(posedge clk) disable iff (rst)
    !s2_q[`FPSL_LED_BASE] [*2] |=> !led_q[`FPSL_LED_BASE])
    else $error("clock LED lit while clock not running");
  qdr_dark_a: assert property (@(posedge clk) disable iff (rst)
    !s2_q[`FPSL_LED_QDR] [*2] |=> !led_q[`FPSL_LED_QDR])
    else $error("QDR LED lit before init");
  ddr_dark_a: assert property (@(posedge clk) disable iff (rst)
    !s2_q[`FPSL_LED_DDR] [*2] |=> !led_q[`FPSL_LED_DDR])
    else $error("DDR LED lit before init");
  srio_steady_a: assert property (@(posedge clk) disable iff (rst)
    (s2_q[`FPSL_LED_SRIO] && ctrl_q[`FPSL_LED_SRIO]) [*2] |->
    led_q[`FPSL_LED_SRIO] ##1 led_q[`FPSL_LED_SRIO] ||
    !s2_q[`FPSL_LED_SRIO] || !ctrl_q[`FPSL_LED_SRIO])
    else $error("link LED not steady on");
endmodule

// ### verification/fpsl_panel.sv
`timescale 1ns/1ps
module fpsl_panel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] led,
  output int half_len [6]
);
  // Operator eye: length of the last finished lit or dark run per LED
  int run [6];
  logic [5:0] seen_q;
  always @(posedge clk) begin
    seen_q <= led;
    for (int i = 0; i < 6; i++) begin
      if (rst) begin
        run[i] <= 0;
        half_len[i] <= 0;
      end else if (led[i] !== seen_q[i]) begin
        half_len[i] <= run[i];
        run[i] <= 1;
      end else begin
        run[i] <= run[i] + 1;
      end
    end
  end
endmodule

// ### verification/front_panel_status_leds_test.sv
`timescale 1ns/1ps
`include "fpsl_map.svh"
module front_panel_status_leds_test;
  import fpsl_pkg::*;
  // Fast half kept a quarter of slow, as the real 2 Hz to 0.5 Hz ratio
  localparam int FH = 2;
  localparam int SH = 8;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, v;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp;
  logic [5:0] ins = '0, m;
  fpsl_led_t led;
  int half_len [6];
  int err_total = 0, cmp_count = 0, cyc = 0;
  logic [1:0] q [$];
  always #10 clk = ~clk;
  assign hready = hreadyout;
  fpsl_top #(.FAST_HALF(FH), .SLOW_HALF(SH)) DUT (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .os_heartbeat(ins[0]),
    .nand_active(ins[1]), .base_clk_running(ins[2]),
    .qdr_init_done(ins[3]), .ddr_init_done(ins[4]),
    .srio_init_done(ins[5]), .led(led));
  fpsl_panel panel (.clk(clk), .rst(rst), .led(led), .half_len(half_len));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask
  task automatic conclude();
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    void'($urandom(11));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(led), 32'h0);
    bus(1'b0, `FPSL_CTRL_OFS, 32'h0);
    chk(rd, 32'h3f);
    // Level LEDs lag their pins by exactly three edges
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      if (q.size() == 4) chk(32'(led[1:0]), 32'(q.pop_front()));
      v = 2'($urandom);
      ins[1:0] <= v;
      q.push_back(v);
    end
    ins[5:2] <= 4'hf;
    repeat (60) @(posedge clk);
    chk(32'(half_len[2]), FH);
    chk(32'(half_len[3]), SH);
    chk(32'(half_len[4]), SH);
    chk(32'(led[5]), 32'h1);
    bus(1'b0, `FPSL_STAT_OFS, 32'h0);
    chk(rd >> 8, 32'(ins));
    chk(32'({rd[5], rd[1:0]}), 32'({1'b1, ins[1:0]}));
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `FPSL_STAT_OFS, 32'h0);
    bus(1'b0, `FPSL_CTRL_OFS, 32'h0);
    chk(rd, 32'h3f);
    m = 6'($urandom) & 6'h1f;
    bus(1'b1, `FPSL_CTRL_OFS, 32'(m));
    bus(1'b0, `FPSL_CTRL_OFS, 32'h0);
    chk(rd, 32'(m));
    repeat (8) @(posedge clk);
    chk(32'(led & ~m), 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(led), 32'h0);
    bus(1'b0, `FPSL_CTRL_OFS, 32'h0);
    chk(rd, 32'h3f);
    conclude();
  end
endmodule
